//--- core/tws_regs.svh
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

// Register byte offsets
`define TWS_OFF_CTRL    8'h00
`define TWS_OFF_STAT    8'h04
`define TWS_OFF_DATA    8'h08
`define TWS_OFF_ISTAT   8'h0C
`define TWS_OFF_IMASK   8'h10

// Control register fields
`define TWS_C_FLAG      7
`define TWS_C_ACKEN     6
`define TWS_C_BEGIN     5
`define TWS_C_END       4
`define TWS_C_WCOL      3
`define TWS_C_EN        2
`define TWS_C_IE        0

// Interrupt status / mask fields
`define TWS_I_STEP      0
`define TWS_I_WCOL      1
`define TWS_I_LOST      2

// Status codes, prescaler bits zero
`define TWS_SC_START    8'h08
`define TWS_SC_RSTART   8'h10
`define TWS_SC_AW_ACK   8'h18
`define TWS_SC_AW_NAK   8'h20
`define TWS_SC_D_ACK    8'h28
`define TWS_SC_D_NAK    8'h30
`define TWS_SC_LOST     8'h38
`define TWS_SC_AR_ACK   8'h40
`define TWS_SC_AR_NAK   8'h48
`define TWS_SC_IDLE     8'hF8

// Timing: quarter of a bus bit period
`define TWS_CLK_MHZ     100
`define TWS_QTR_NS      2500
`define TWS_QTR_CYC     ((`TWS_QTR_NS * `TWS_CLK_MHZ) / 1000)

`endif

//--- core/tws_pkg.sv
package tws_pkg;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_START = 5'b00010,
        ST_XFER  = 5'b00100,
        ST_STOP  = 5'b01000,
        ST_HOLD  = 5'b10000
    } tws_fsm_t;

    typedef struct packed {
        tws_fsm_t    fsm;
        logic [1:0]  ph;
        logic [7:0]  div;
        logic [3:0]  bitn;
        logic [7:0]  sh;
        logic        ack;
        logic        rep;
        logic        addr;
        logic        rdbit;
        logic        fetch;
        logic        busy;
        logic        sda_q;
        logic        flag;
        logic        acken;
        logic        beg;
        logic        fin;
        logic        wcol;
        logic        en;
        logic        ie;
        logic [7:0]  code;
        logic [1:0]  psc;
        logic [7:0]  data;
        logic [2:0]  istat;
        logic [2:0]  imask;
        logic        rdy;
        logic [31:0] prdata;
        logic        slverr;
        logic        irq;
        logic        scl_oe;
        logic        sda_oe;
    } tws_state_t;

endpackage : tws_pkg

//--- core/tws_sync.sv
`timescale 1ns/1ps
module tws_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Asynchronous in, synchronised out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // First stage feeds only the second
    logic [W-1:0] meta_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_reg[i] <= 1'b1;
                    q[i]        <= 1'b1;
                end else begin
                    meta_reg[i] <= d[i];
                    q[i]        <= meta_reg[i];
                end
            end
        end
    endgenerate
endmodule : tws_sync

//--- core/tws_seq.sv
`timescale 1ns/1ps
`include "tws_regs.svh"
// Behaviour
// - After a repeated START report 0x10; any target may follow, no STOP.
// - Repeated START keeps bus ownership while target or direction changes.
// - After START report 0x08; address with write bit then goes out, ack sampled.
// - In 0x10 an address with read bit is sent and fetch mode entered.
// - Address with write bit reports 0x18 on ack, 0x20 on no ack.
// - Data byte reports 0x28 on ack, 0x30 on no ack.
// - In 0x18 to 0x30 a plain flag clear sends the loaded byte.
// - In those states begin 1 with flag clear issues a repeated START.
// - End 1 with flag clear sends STOP, then end clears itself.
// - Begin and end both 1 send STOP then START; end clears after STOP.
// - Arbitration loss in address or data byte reports 0x38.
// - In 0x38 flag clear with begin 0 releases bus, unaddressed.
// - In 0x38 flag clear with begin 1 waits for idle bus, then START.
// - Transfers halt while the step flag is set; writing one resumes.
// - Data write while flag low is dropped and sets write collision.
// - START waits for a free bus, then sets the step flag.
module tws_seq (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt
    output logic             irq,
    // Open-drain bus pins, low while enabled
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe
);
    import tws_pkg::*;

    tws_state_t s;
    tws_state_t n;
    logic [1:0] pins_s;
    logic       scl_s;
    logic       sda_s;

    // Register index from address, 3'd7 when unmapped
    function automatic logic [2:0] reg_sel(input logic [7:0] a);
        logic [2:0] r;
        r = 3'd7;
        if (a == `TWS_OFF_CTRL)  r = 3'd0;
        if (a == `TWS_OFF_STAT)  r = 3'd1;
        if (a == `TWS_OFF_DATA)  r = 3'd2;
        if (a == `TWS_OFF_ISTAT) r = 3'd3;
        if (a == `TWS_OFF_IMASK) r = 3'd4;
        return r;
    endfunction : reg_sel

    tws_sync #(
        .W (2)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({scl_in, sda_in}),
        .q     (pins_s)
    );
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    always_comb begin
        logic [2:0] sel;
        logic       tick;
        logic       acc;
        logic       wr;
        logic       cwr;
        logic       w_beg;
        logic       w_end;
        logic       post;
        sel   = reg_sel(paddr);
        tick  = (s.div == 8'h00);
        acc   = psel & penable & ~s.rdy;
        wr    = psel & penable & s.rdy & pwrite & ~s.slverr;
        cwr   = wr & (sel == 3'd0);
        w_beg = pwdata[`TWS_C_BEGIN];
        w_end = pwdata[`TWS_C_END];
        post  = (s.code == `TWS_SC_AW_ACK) || (s.code == `TWS_SC_AW_NAK) ||
                (s.code == `TWS_SC_D_ACK)  || (s.code == `TWS_SC_D_NAK);
        n = s;
        n.div = tick ? 8'(`TWS_QTR_CYC - 1) : s.div - 8'h01;

        // Bus monitor: own and foreign START/STOP alike
        n.sda_q = sda_s;
        if (scl_s && s.sda_q && !sda_s) begin
            n.busy = 1'b1;
        end
        if (scl_s && !s.sda_q && sda_s) begin
            n.busy = 1'b0;
        end

        // APB: one wait state, answer registered
        n.rdy = acc;
        if (acc) begin
            n.slverr = (sel == 3'd7);
            unique case (sel)
                3'd0: n.prdata = {24'h00_0000, s.flag, s.acken, s.beg, s.fin,
                                  s.wcol, s.en, 1'b0, s.ie};
                3'd1: n.prdata = {24'h00_0000, s.code[7:3], 1'b0, s.psc};
                3'd2: n.prdata = {24'h00_0000, s.data};
                3'd3: n.prdata = {29'h0000_0000, s.istat};
                3'd4: n.prdata = {29'h0000_0000, s.imask};
                default: n.prdata = 32'h0000_0000;
            endcase
        end else if (s.rdy) begin
            n.slverr = 1'b0;
        end

        if (wr && sel == 3'd1) begin
            n.psc = pwdata[1:0];
        end
        if (wr && sel == 3'd4) begin
            n.imask = pwdata[2:0];
        end
        if (wr && sel == 3'd3) begin
            n.istat = s.istat & ~pwdata[2:0];
        end
        if (wr && sel == 3'd2) begin
            if (s.flag) begin
                n.data = pwdata[7:0];
                n.wcol = 1'b0;
            end else begin
                n.wcol = 1'b1;
                n.istat[`TWS_I_WCOL] = 1'b1;
            end
        end

        if (cwr) begin
            n.acken = pwdata[`TWS_C_ACKEN];
            n.beg   = w_beg;
            n.fin   = w_end;
            n.en    = pwdata[`TWS_C_EN];
            n.ie    = pwdata[`TWS_C_IE];
        end

        // Flag clear launches the next step; nothing moves while set
        if (cwr && pwdata[`TWS_C_FLAG] && pwdata[`TWS_C_EN] &&
            (s.flag || s.fsm == ST_IDLE)) begin
            n.flag = 1'b0;
            n.ph   = 2'd0;
            if (s.fsm == ST_IDLE) begin
                if (w_beg) begin
                    n.fsm = ST_START;
                    n.rep = 1'b0;
                end
            end else if (s.code == `TWS_SC_LOST) begin
                if (w_beg) begin
                    n.fsm = ST_START;
                    n.rep = 1'b0;
                end else begin
                    n.fsm  = ST_IDLE;
                    n.code = `TWS_SC_IDLE;
                    n.scl_oe = 1'b0;
                    n.sda_oe = 1'b0;
                end
            end else if (w_end) begin
                n.fsm = ST_STOP;
            end else if (w_beg) begin
                n.fsm = ST_START;
                n.rep = 1'b1;
            end else if (!s.fetch || s.code == `TWS_SC_START ||
                         s.code == `TWS_SC_RSTART) begin
                n.fsm   = ST_XFER;
                n.sh    = s.data;
                n.bitn  = 4'd0;
                n.addr  = (s.code == `TWS_SC_START) || (s.code == `TWS_SC_RSTART);
                n.rdbit = s.data[0];
                if (!n.addr && !post) begin
                    n.fsm = ST_HOLD;
                end
            end
        end

        unique case (s.fsm)
            ST_IDLE: begin
                n.scl_oe = 1'b0;
                n.sda_oe = 1'b0;
            end
            ST_START: begin
                if (tick) begin
                    unique case (s.ph)
                        2'd0: begin
                            n.sda_oe = 1'b0;
                            // Fresh START waits out foreign traffic
                            if (s.rep || !s.busy) begin
                                n.ph = 2'd1;
                            end
                        end
                        2'd1: begin
                            n.scl_oe = 1'b0;
                            n.ph     = 2'd2;
                        end
                        2'd2: begin
                            if (scl_s && sda_s) begin
                                n.sda_oe = 1'b1;
                                n.ph     = 2'd3;
                            end
                        end
                        2'd3: begin
                            n.scl_oe = 1'b1;
                            n.fsm    = ST_HOLD;
                            n.flag   = 1'b1;
                            n.fetch  = 1'b0;
                            n.code   = s.rep ? `TWS_SC_RSTART : `TWS_SC_START;
                            n.ph     = 2'd0;
                        end
                        default: n.ph = 2'd0;
                    endcase
                end
            end
            ST_XFER: begin
                if (tick) begin
                    unique case (s.ph)
                        2'd0: begin
                            n.sda_oe = (s.bitn < 4'd8) ? ~s.sh[7] : 1'b0;
                            n.ph     = 2'd1;
                        end
                        2'd1: begin
                            n.scl_oe = 1'b0;
                            n.ph     = 2'd2;
                        end
                        2'd2: begin
                            // Slave stretching holds us here
                            if (scl_s) begin
                                n.ph = 2'd3;
                                if (s.bitn < 4'd8 && s.sh[7] && !sda_s) begin
                                    n.fsm    = ST_HOLD;
                                    n.code   = `TWS_SC_LOST;
                                    n.flag   = 1'b1;
                                    n.sda_oe = 1'b0;
                                    n.istat[`TWS_I_LOST] = 1'b1;
                                    n.ph     = 2'd0;
                                end else if (s.bitn == 4'd8) begin
                                    n.ack = ~sda_s;
                                end else begin
                                    n.sh = {s.sh[6:0], 1'b0};
                                end
                            end
                        end
                        2'd3: begin
                            n.scl_oe = 1'b1;
                            n.ph     = 2'd0;
                            n.bitn   = s.bitn + 4'd1;
                            if (s.bitn == 4'd8) begin
                                n.fsm  = ST_HOLD;
                                n.flag = 1'b1;
                                if (s.addr && s.rdbit) begin
                                    n.fetch = 1'b1;
                                    n.code  = s.ack ? `TWS_SC_AR_ACK : `TWS_SC_AR_NAK;
                                end else if (s.addr) begin
                                    n.code = s.ack ? `TWS_SC_AW_ACK : `TWS_SC_AW_NAK;
                                end else begin
                                    n.code = s.ack ? `TWS_SC_D_ACK : `TWS_SC_D_NAK;
                                end
                            end
                        end
                        default: n.ph = 2'd0;
                    endcase
                end
            end
            ST_STOP: begin
                if (tick) begin
                    unique case (s.ph)
                        2'd0: begin
                            n.sda_oe = 1'b1;
                            n.ph     = 2'd1;
                        end
                        2'd1: begin
                            n.scl_oe = 1'b0;
                            n.ph     = 2'd2;
                        end
                        2'd2: begin
                            if (scl_s) begin
                                n.sda_oe = 1'b0;
                                n.ph     = 2'd3;
                            end
                        end
                        2'd3: begin
                            n.fin   = 1'b0;
                            n.fetch = 1'b0;
                            n.code  = `TWS_SC_IDLE;
                            n.ph    = 2'd0;
                            n.rep   = 1'b0;
                            n.fsm   = s.beg ? ST_START : ST_IDLE;
                        end
                        default: n.ph = 2'd0;
                    endcase
                end
            end
            ST_HOLD: begin
                // Parked; only a flag clear above or clearing the enable bit moves it on
            end
            default: n.fsm = ST_IDLE;
        endcase

        if (n.flag && !s.flag) begin
            n.istat[`TWS_I_STEP] = 1'b1;
        end
        // Disabling drops any transfer and frees the pins
        if (!n.en) begin
            n.fsm    = ST_IDLE;
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
            n.ph     = 2'd0;
        end
        n.irq = |(n.istat & n.imask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s       <= '0;
            s.fsm   <= ST_IDLE;
            s.code  <= `TWS_SC_IDLE;
            s.sda_q <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign prdata  = s.prdata;
    assign pready  = s.rdy;
    assign pslverr = s.slverr;
    assign irq     = s.irq;
    assign scl_oe  = s.scl_oe;
    assign sda_oe  = s.sda_oe;
    // Open drain: only ever pulls low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
endmodule : tws_seq

//--- tb/tws_seq_assertions.sv
`timescale 1ns/1ps
module tws_seq_assertions (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Interrupt and bus pins
    input wire logic        irq,
    input wire logic        scl_out,
    input wire logic        scl_oe,
    input wire logic        sda_out,
    input wire logic        sda_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence acc_wait;
        psel && penable && !pready;
    endsequence
    sequence one_pulse;
        pready ##1 !pready;
    endsequence
    sequence quiet_flag;
        irq && !psel && !$past(psel);
    endsequence

    ready_once_a: assert property (acc_wait |=> one_pulse)
        else $error("pready not one pulse after access");
    ready_cause_a: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready without access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr outside answer");
    err_rdzero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    drive_low_a: assert property (scl_out == 1'h0 && sda_out == 1'h0)
        else $error("pin driven high");
    halt_hold_a: assert property (quiet_flag |=> irq && $stable(scl_oe) && $stable(sda_oe))
        else $error("bus moved while step flag set");
    scl_low_a: assert property ($rose(scl_oe) |=> scl_oe [*8])
        else $error("clock low phase too short");
    scl_high_a: assert property ($fell(scl_oe) |=> !scl_oe [*8])
        else $error("clock high phase too short");
endmodule : tws_seq_assertions

bind tws_seq tws_seq_assertions tws_seq_assertions_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe)
);

//--- tb/tws_bus_model.sv
`timescale 1ns/1ps
module tws_bus_model (
    // Wires, pulled up
    input  wire logic       scl,
    input  wire logic       sda,
    // Behaviour chosen by the bench
    input  wire logic       ack_on,
    input  wire logic       steal,
    // Pull on data line, last byte taken
    output logic            sda_oe,
    output logic [7:0]      last_byte
);
    int         cnt;
    logic       frame;
    logic       ack_drv;
    logic       hog;
    logic [7:0] sh;

    initial begin
        cnt = 0;
        frame = 1'h0;
        ack_drv = 1'h0;
        hog = 1'h0;
        sh = 8'h00;
        last_byte = 8'h00;
    end
    assign sda_oe = ack_drv || hog;
    always @(negedge sda) begin
        if (scl) begin
            frame = 1'h1;
            cnt = 0;
        end
    end
    always @(posedge sda) begin
        if (scl) frame = 1'h0;
    end
    always @(posedge scl) begin
        if (frame && cnt < 8) begin
            sh = {sh[6:0], sda};
            cnt++;
            if (cnt == 8) last_byte = sh;
        end
    end
    // Only moves data while clock is low, so no false start or stop
    always @(negedge scl) begin
        if (cnt == 8) begin
            ack_drv = ack_on;
            cnt = 9;
        end else if (cnt == 9) begin
            ack_drv = 1'h0;
            cnt = 0;
        end else if (steal && frame) begin
            hog = 1'h1;
        end
    end
    // Let go with clock high: other master ends with a stop
    always @(negedge steal) hog = 1'h0;
endmodule : tws_bus_model

//--- tb/testbench.sv
`timescale 1ns/1ps
`include "tws_regs.svh"
module testbench;
    import tws_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr, a, b, last_byte;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, irq, er;
    logic        scl_out, scl_oe, sda_out, sda_oe, ack_on, steal, m_oe;
    wire         scl = !scl_oe;
    wire         sda = !(sda_oe || m_oe);
    int          bad_count, n_checks, seed;
    logic [7:0]  offs [5] = '{`TWS_OFF_CTRL, `TWS_OFF_STAT, `TWS_OFF_DATA, `TWS_OFF_ISTAT,
                              `TWS_OFF_IMASK};
    logic [7:0]  rstv [5] = '{8'h00, `TWS_SC_IDLE, 8'h00, 8'h00, 8'h00};

    tws_seq tws_seq_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
    tws_bus_model tws_bus_model_i (.scl(scl), .sda(sda), .ack_on(ack_on), .steal(steal),
        .sda_oe(m_oe), .last_byte(last_byte));

    always #5 pclk = !pclk;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            bad_count++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    function automatic logic [7:0] ack_code(input logic adr, input logic ack);
        if (adr) return ack ? `TWS_SC_AW_ACK : `TWS_SC_AW_NAK;
        return ack ? `TWS_SC_D_ACK : `TWS_SC_D_NAK;
    endfunction : ack_code

    task automatic finish_step(input logic [7:0] code, input string nm);
        int n;
        n = 0;
        while (irq !== 1'h1 && n < 12000) begin
            @(posedge pclk);
            n++;
        end
        if (irq !== 1'h1) begin
            bad_count++;
            end_sim();
        end
        apb(1'h1, `TWS_OFF_ISTAT, 8'h01);
        apb(1'h0, `TWS_OFF_STAT, 8'h00);
        chk(nm, rd & 32'h0000_00F8, {24'h00_0000, code});
        $display("test %s done", nm);
    endtask : finish_step

    task automatic step(input logic [7:0] c, input logic [7:0] code, input string nm);
        apb(1'h1, `TWS_OFF_CTRL, c);
        finish_step(code, nm);
    endtask : step

    task automatic send(input logic [7:0] v, input logic ack, input logic [7:0] code,
                        input string nm);
        ack_on <= ack;
        apb(1'h1, `TWS_OFF_DATA, v);
        step(8'h84, code, nm);
        chk("byte on wire", {24'h00_0000, last_byte}, {24'h00_0000, v});
    endtask : send

    task automatic poll(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] v,
                        input string nm);
        int n;
        n = 0;
        do begin
            apb(1'h0, ad, 8'h00);
            n++;
        end while ((rd[7:0] & m) !== v && n < 400);
        chk(nm, rd[7:0] & m, v);
        if ((rd[7:0] & m) !== v) begin
            end_sim();
        end
    endtask : poll

    initial begin
        pclk = 1'h0;
        presetn = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ack_on, steal} = 2'h0;
        bad_count = 0;
        n_checks = 0;
        seed = 32'h53fd;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        for (int i = 0; i < 5; i++) begin
            apb(1'h0, offs[i], 8'h00);
            chk("reset value", rd, {24'h00_0000, rstv[i]});
        end
        apb(1'h0, 8'h14, 8'h00);
        chk("unmapped error", {31'h0, er}, 32'h0000_0001);
        apb(1'h1, `TWS_OFF_STAT, 8'h03);
        apb(1'h0, `TWS_OFF_STAT, 8'h00);
        chk("prescaler bits", rd, 32'h0000_00FB);
        apb(1'h1, `TWS_OFF_IMASK, 8'h01);
        a = 8'($random(seed));
        step(8'hA4, `TWS_SC_START, "start");
        send({a[6:0], 1'h0}, 1'h1, ack_code(1'h1, 1'h1), "address ack");
        b = 8'($random(seed));
        ack_on <= 1'h0;
        apb(1'h1, `TWS_OFF_DATA, b);
        apb(1'h1, `TWS_OFF_CTRL, 8'h84);
        apb(1'h1, `TWS_OFF_DATA, ~b);
        apb(1'h0, `TWS_OFF_CTRL, 8'h00);
        chk("collision bit", {31'h0, rd[3]}, 32'h0000_0001);
        apb(1'h0, `TWS_OFF_DATA, 8'h00);
        chk("data kept", rd, {24'h00_0000, b});
        apb(1'h0, `TWS_OFF_ISTAT, 8'h00);
        chk("collision event", rd, 32'h0000_0002);
        chk("masked irq", {31'h0, irq}, 32'h0000_0000);
        apb(1'h1, `TWS_OFF_ISTAT, 8'h02);
        finish_step(ack_code(1'h0, 1'h0), "data nak");
        chk("byte on wire", {24'h00_0000, last_byte}, {24'h00_0000, b});
        send(8'($random(seed)), 1'h1, ack_code(1'h0, 1'h1), "data ack");
        step(8'hA4, `TWS_SC_RSTART, "repeated start");
        send({~a[6:0], 1'h0}, 1'h0, ack_code(1'h1, 1'h0), "new target");
        steal <= 1'h1;
        apb(1'h1, `TWS_OFF_DATA, 8'hFF);
        step(8'h84, `TWS_SC_LOST, "lost in data");
        apb(1'h1, `TWS_OFF_CTRL, 8'h84);
        poll(`TWS_OFF_STAT, 8'hF8, `TWS_SC_IDLE, "released");
        chk("bus let go", {30'h0, scl_oe, sda_oe}, 32'h0000_0000);
        steal <= 1'h0;
        step(8'hA4, `TWS_SC_START, "start again");
        steal <= 1'h1;
        apb(1'h1, `TWS_OFF_DATA, {a[6:0] | 7'h60, 1'h0});
        step(8'h84, `TWS_SC_LOST, "lost in address");
        apb(1'h1, `TWS_OFF_CTRL, 8'hA4);
        repeat (1200) @(posedge pclk);
        chk("waits for free bus", {31'h0, irq}, 32'h0000_0000);
        steal <= 1'h0;
        finish_step(`TWS_SC_START, "start after loss");
        send({a[6:0], 1'h0}, 1'h1, ack_code(1'h1, 1'h1), "address ack 2");
        apb(1'h1, `TWS_OFF_CTRL, 8'h94);
        poll(`TWS_OFF_CTRL, 8'h10, 8'h00, "stop clears end");
        poll(`TWS_OFF_STAT, 8'hF8, `TWS_SC_IDLE, "stop sent");
        step(8'hA4, `TWS_SC_START, "start 3");
        send({a[6:0], 1'h0}, 1'h1, ack_code(1'h1, 1'h1), "address ack 3");
        step(8'hB4, `TWS_SC_START, "stop then start");
        apb(1'h0, `TWS_OFF_CTRL, 8'h00);
        chk("end cleared", {31'h0, rd[4]}, 32'h0000_0000);
        send({a[6:0], 1'h0}, 1'h1, ack_code(1'h1, 1'h1), "address ack 4");
        step(8'hA4, `TWS_SC_RSTART, "repeated start 2");
        send({a[6:0], 1'h1}, 1'h1, `TWS_SC_AR_ACK, "read address");
        end_sim();
    end
endmodule : testbench
